//--- core/cwp_config_word0.sv
// Configuration word zero decoder with APB register file
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module cwp_config_word0 #(
  parameter int unsigned          FLASH_KB      = 256,
  parameter int unsigned          FA_W          = 20,
  parameter bit                   PAIR4_PRESENT = 1'b1,
  // Arbitrary identification values
  parameter logic [3:0]           REVISION      = 4'h1,
  parameter logic [27:0]          DEVICE_CODE   = 28'h0a5c3e1
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [15:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [31:0]        boot_config_word_zero,
  input  wire logic [FA_W-1:0]    flash_write_addr,
  output logic                    config_loaded,
  output logic                    ext_programmer_block,
  output logic                    boot_flash_write_block,
  output logic      [FA_W-1:0]    program_flash_protect_bound,
  output logic                    program_flash_protect_all,
  output logic                    flash_write_blocked,
  output logic      [3:0]         debug_pin_pair_select,
  output logic                    debugger_enable,
  output logic                    scan_port_enable,
  output logic                    test_data_out_enable,
  output logic                    pin_select_lock,
  output logic                    power_module_lock
);

  localparam int unsigned PF_IMPL_W =
    (FLASH_KB >= 256) ? cwp_pkg::PWP_W : cwp_pkg::PWP_W - 2;

  initial
  begin
    if (FA_W < cwp_pkg::PWP_W + cwp_pkg::PF_PAGE_SHIFT || FA_W > 32)
      $error("cwp_config_word0: FA_W out of range");
    if (FLASH_KB == 0)
      $error("cwp_config_word0: FLASH_KB must be non-zero");
  end

  logic [31:0]     word_reg;
  logic            loaded_reg;
  logic [31:0]     ctrl_reg;
  logic [31:0]     key_reg;
  logic [31:0]     rdata_reg;
  logic            cp_active_reg;
  logic            boot_block_reg;
  logic [FA_W-1:0] bound_reg;
  logic            pf_all_reg;
  logic            wr_block_reg;
  logic [3:0]      pair_reg;
  logic            dbg_en_reg;

  logic [FA_W-1:0] bound_next;
  logic            pf_all_next;
  logic            addr_prot_next;
  logic [3:0]      pair_next;
  logic            dbg_en_next;
  logic            cp_active_next;

  logic            setup_phase;
  logic            access_phase;
  logic            addr_hit;
  logic            wr_ctrl;
  logic            wr_key;
  logic [31:0]     byte_mask;
  logic [31:0]     rdata_next;
  logic [31:0]     status_word;

  // Word zero capture, once after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_reg   <= 32'h00000000;
      loaded_reg <= 1'b0;
    end
    else if (!loaded_reg)
    begin
      word_reg   <= boot_config_word_zero;
      loaded_reg <= 1'b1;
    end
  end

  // Before capture the cleared word keeps every protection engaged
  assign cp_active_next = ~word_reg[cwp_pkg::W0_CODE_PROTECT];

  cwp_flash_bound #(
    .IMPL_W    (PF_IMPL_W),
    .FA_W      (FA_W)
  ) u_flash_bound (
    .field     (word_reg[cwp_pkg::W0_PWP_HI:cwp_pkg::W0_PWP_LO]),
    .addr      (flash_write_addr),
    .bound     (bound_next),
    .all_prot  (pf_all_next),
    .addr_prot (addr_prot_next)
  );

  cwp_debug_route #(
    .PAIR4_PRESENT (PAIR4_PRESENT)
  ) u_debug_route (
    .sel         (word_reg[cwp_pkg::W0_DBG_SEL_HI:cwp_pkg::W0_DBG_SEL_LO]),
    .debug_field (word_reg[cwp_pkg::W0_DEBUG_HI:cwp_pkg::W0_DEBUG_LO]),
    .cp_active   (cp_active_next),
    .pair_onehot (pair_next),
    .debugger_en (dbg_en_next)
  );

  // Decoded protection controls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cp_active_reg  <= 1'b1;
      boot_block_reg <= 1'b1;
      bound_reg      <= '0;
      pf_all_reg     <= 1'b1;
      wr_block_reg   <= 1'b1;
    end
    else
    begin
      cp_active_reg  <= cp_active_next;
      boot_block_reg <= ~word_reg[cwp_pkg::W0_BOOT_WP];
      bound_reg      <= bound_next;
      pf_all_reg     <= pf_all_next;
      wr_block_reg   <= addr_prot_next;
    end
  end

  // Decoded debug controls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pair_reg   <= 4'h0;
      dbg_en_reg <= 1'b0;
    end
    else
    begin
      pair_reg   <= loaded_reg ? pair_next : 4'h0;
      dbg_en_reg <= loaded_reg & dbg_en_next;
    end
  end

  // APB decode
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign pready       = 1'b1;

  always_comb
  begin
    unique case (paddr)
      cwp_pkg::OFS_CONFIG_CONTROL,
      cwp_pkg::OFS_WORD_ZERO,
      cwp_pkg::OFS_DECODE_STATUS,
      cwp_pkg::OFS_PART_ID,
      cwp_pkg::OFS_UNLOCK_KEY: addr_hit = 1'b1;
      default:                 addr_hit = 1'b0;
    endcase
  end

  assign pslverr = access_phase & ~addr_hit;
  assign wr_ctrl = access_phase & pwrite &
                   (paddr == cwp_pkg::OFS_CONFIG_CONTROL);
  assign wr_key  = access_phase & pwrite &
                   (paddr == cwp_pkg::OFS_UNLOCK_KEY);

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      byte_mask[i*8 +: 8] = {8{pstrb[i]}};
  end

  // Configuration control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= cwp_pkg::CC_RESET;
    else if (!loaded_reg)
      ctrl_reg[cwp_pkg::CC_SCAN_EN] <=
        boot_config_word_zero[cwp_pkg::W0_SCAN_EN];
    else if (wr_ctrl)
      ctrl_reg <= (ctrl_reg & ~(cwp_pkg::CC_WRITE_MASK & byte_mask)) |
                  (pwdata & cwp_pkg::CC_WRITE_MASK & byte_mask);
  end

  // System unlock key register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      key_reg <= cwp_pkg::UNLOCK_RESET;
    else if (wr_key)
      key_reg <= (key_reg & ~byte_mask) | (pwdata & byte_mask);
  end

  always_comb
  begin
    status_word = 32'h00000000;
    status_word[cwp_pkg::DS_LOADED]     = loaded_reg;
    status_word[cwp_pkg::DS_CP_ACTIVE]  = cp_active_reg;
    status_word[cwp_pkg::DS_BOOT_BLOCK] = boot_block_reg;
    status_word[cwp_pkg::DS_PF_ALL]     = pf_all_reg;
    status_word[cwp_pkg::DS_PAIR_LO +: 4] = pair_reg;
    status_word[cwp_pkg::DS_DBG_EN]     = dbg_en_reg;
    status_word[cwp_pkg::DS_PAGES_LO +: cwp_pkg::PWP_W] =
      bound_reg[cwp_pkg::PF_PAGE_SHIFT +: cwp_pkg::PWP_W];
  end

  always_comb
  begin
    unique case (paddr)
      cwp_pkg::OFS_CONFIG_CONTROL: rdata_next = ctrl_reg;
      cwp_pkg::OFS_WORD_ZERO:      rdata_next = word_reg;
      cwp_pkg::OFS_DECODE_STATUS:  rdata_next = status_word;
      cwp_pkg::OFS_PART_ID:        rdata_next = {REVISION, DEVICE_CODE};
      cwp_pkg::OFS_UNLOCK_KEY:     rdata_next = key_reg;
      default:                     rdata_next = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup phase, so pready can stay high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_reg <= 32'h00000000;
    else if (setup_phase && !pwrite)
      rdata_reg <= rdata_next;
  end

  assign prdata                      = rdata_reg;
  assign config_loaded               = loaded_reg;
  assign ext_programmer_block        = cp_active_reg;
  assign boot_flash_write_block      = boot_block_reg;
  assign program_flash_protect_bound = bound_reg;
  assign program_flash_protect_all   = pf_all_reg;
  assign flash_write_blocked         = wr_block_reg;
  assign debug_pin_pair_select       = pair_reg;
  assign debugger_enable             = dbg_en_reg;
  assign scan_port_enable            = ctrl_reg[cwp_pkg::CC_SCAN_EN];
  assign test_data_out_enable        = ctrl_reg[cwp_pkg::CC_TDO_EN];
  assign pin_select_lock             = ctrl_reg[cwp_pkg::CC_PIN_LOCK];
  assign power_module_lock           = ctrl_reg[cwp_pkg::CC_PWR_LOCK];

  // Checks

  property p_code_protect;
    @(posedge pclk) disable iff (!presetn)
      loaded_reg && !word_reg[cwp_pkg::W0_CODE_PROTECT]
      |=> ext_programmer_block && !debugger_enable;
  endproperty
  a_code_protect: assert property (p_code_protect)
    else $error("code protection not applied");

  property p_boot_wp;
    @(posedge pclk) disable iff (!presetn)
      loaded_reg |=>
      boot_flash_write_block == !$past(word_reg[cwp_pkg::W0_BOOT_WP]);
  endproperty
  a_boot_wp: assert property (p_boot_wp)
    else $error("boot flash protect mismatch");

  property p_pf_bound;
    @(posedge pclk) disable iff (!presetn)
      loaded_reg && PF_IMPL_W == cwp_pkg::PWP_W |=>
      program_flash_protect_bound ==
      ({{(FA_W-cwp_pkg::PWP_W){1'b0}},
        ~$past(word_reg[cwp_pkg::W0_PWP_HI:cwp_pkg::W0_PWP_LO])}
       << cwp_pkg::PF_PAGE_SHIFT);
  endproperty
  a_pf_bound: assert property (p_pf_bound)
    else $error("program flash boundary wrong");

  property p_pf_all;
    @(posedge pclk) disable iff (!presetn)
      loaded_reg |=> program_flash_protect_all ==
      ($past(word_reg[cwp_pkg::W0_PWP_LO +: PF_IMPL_W]) == '0) &&
      (!program_flash_protect_all || flash_write_blocked);
  endproperty
  a_pf_all: assert property (p_pf_all)
    else $error("all-protect did not block write");

  property p_flash_block;
    @(posedge pclk) disable iff (!presetn)
      flash_write_blocked == (program_flash_protect_all ||
      $past(flash_write_addr) < program_flash_protect_bound);
  endproperty
  a_flash_block: assert property (p_flash_block)
    else $error("flash write block wrong");

  property p_pair_onehot;
    @(posedge pclk) disable iff (!presetn)
      loaded_reg |=> $onehot0(debug_pin_pair_select) &&
      debug_pin_pair_select ==
      ((4'h8 >>
        $past(word_reg[cwp_pkg::W0_DBG_SEL_HI:cwp_pkg::W0_DBG_SEL_LO])) &
       {PAIR4_PRESENT, 3'h7});
  endproperty
  a_pair_onehot: assert property (p_pair_onehot)
    else $error("debug pair select invalid");

  property p_scan_load;
    @(posedge pclk) disable iff (!presetn)
      presetn && !loaded_reg |=>
      scan_port_enable == $past(boot_config_word_zero[cwp_pkg::W0_SCAN_EN]);
  endproperty
  a_scan_load: assert property (p_scan_load)
    else $error("scan enable not loaded from word zero");

  property p_word_hold;
    @(posedge pclk) disable iff (!presetn)
      loaded_reg |=> loaded_reg && $stable(word_reg) ##1 $stable(word_reg);
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("word zero changed after capture");

  property p_key_write;
    @(posedge pclk) disable iff (!presetn)
      wr_key && pstrb == 4'hf |=> key_reg == $past(pwdata);
  endproperty
  a_key_write: assert property (p_key_write)
    else $error("unlock key write lost");

  property p_ctrl_reserved;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_reg & ~cwp_pkg::CC_WRITE_MASK) ==
      (cwp_pkg::CC_RESET & ~cwp_pkg::CC_WRITE_MASK);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("control register reserved bits changed");

endmodule : cwp_config_word0

//--- core/cwp_pkg.sv
// Shared constants for the configuration word zero protection decoder
package cwp_pkg;

  // Register byte offsets on the APB bus
  localparam int unsigned    ADDR_W             = 16;
  localparam logic [15:0]    OFS_CONFIG_CONTROL = 16'he000;
  localparam logic [15:0]    OFS_WORD_ZERO      = 16'he010;
  localparam logic [15:0]    OFS_DECODE_STATUS  = 16'he020;
  localparam logic [15:0]    OFS_PART_ID        = 16'hf220;
  localparam logic [15:0]    OFS_UNLOCK_KEY     = 16'hf230;

  // Configuration word zero fields
  localparam int unsigned    W0_CODE_PROTECT    = 28;
  localparam int unsigned    W0_BOOT_WP         = 24;
  localparam int unsigned    W0_PWP_HI          = 18;
  localparam int unsigned    W0_PWP_LO          = 10;
  localparam int unsigned    W0_DBG_SEL_HI      = 4;
  localparam int unsigned    W0_DBG_SEL_LO      = 3;
  localparam int unsigned    W0_SCAN_EN         = 2;
  localparam int unsigned    W0_DEBUG_HI        = 1;
  localparam int unsigned    W0_DEBUG_LO        = 0;
  localparam int unsigned    PWP_W              = 9;
  localparam int unsigned    PF_PAGE_SHIFT      = 10;
  localparam logic [1:0]     DEBUG_FORCED_OFF   = 2'h3;

  // Debug channel encodings
  localparam logic [1:0]     DBG_SEL_PAIR_ONE   = 2'h3;
  localparam logic [1:0]     DBG_SEL_PAIR_TWO   = 2'h2;
  localparam logic [1:0]     DBG_SEL_PAIR_THREE = 2'h1;
  localparam logic [1:0]     DBG_SEL_PAIR_FOUR  = 2'h0;

  // Configuration control fields
  localparam int unsigned    CC_PIN_LOCK        = 13;
  localparam int unsigned    CC_PWR_LOCK        = 12;
  localparam int unsigned    CC_SCAN_EN         = 3;
  localparam int unsigned    CC_FIXED_ONE       = 1;
  localparam int unsigned    CC_TDO_EN          = 0;
  localparam logic [31:0]    CC_RESET           = 32'h0000000b;
  localparam logic [31:0]    CC_WRITE_MASK      = 32'h00003009;
  localparam logic [31:0]    UNLOCK_RESET       = 32'h00000000;

  // Part identification layout
  localparam int unsigned    REV_W              = 4;
  localparam int unsigned    CODE_W             = 28;

  // Decode status fields
  localparam int unsigned    DS_LOADED          = 0;
  localparam int unsigned    DS_CP_ACTIVE       = 1;
  localparam int unsigned    DS_BOOT_BLOCK      = 2;
  localparam int unsigned    DS_PF_ALL          = 3;
  localparam int unsigned    DS_PAIR_LO         = 4;
  localparam int unsigned    DS_DBG_EN          = 8;
  localparam int unsigned    DS_PAGES_LO        = 16;

endpackage : cwp_pkg

//--- core/cwp_flash_bound.sv
// Program flash write-protect boundary decode
`timescale 1ns/1ps
module cwp_flash_bound #(
  parameter int unsigned IMPL_W = 9,
  parameter int unsigned FA_W   = 20
) (
  input  wire logic [cwp_pkg::PWP_W-1:0] field,
  input  wire logic [FA_W-1:0]           addr,
  output logic      [FA_W-1:0]           bound,
  output logic                           all_prot,
  output logic                           addr_prot
);

  logic [cwp_pkg::PWP_W-1:0] eff_field;

  initial
  begin
    if (IMPL_W < 1 || IMPL_W > cwp_pkg::PWP_W)
      $error("cwp_flash_bound: bad IMPL_W");
    if (FA_W < cwp_pkg::PWP_W + cwp_pkg::PF_PAGE_SHIFT)
      $error("cwp_flash_bound: FA_W too narrow");
  end

  always_comb
  begin
    // Missing upper bits behave as ones
    eff_field = '1;
    eff_field[IMPL_W-1:0] = field[IMPL_W-1:0];
    // Boundary is the inverted field in 1 KB pages
    bound = {{(FA_W-cwp_pkg::PWP_W){1'b0}}, ~eff_field}
            << cwp_pkg::PF_PAGE_SHIFT;
    all_prot = (field[IMPL_W-1:0] == '0);
    addr_prot = all_prot || (addr < bound);
  end

endmodule : cwp_flash_bound

//--- core/cwp_debug_route.sv
// Debugger channel routing and background debugger enable
`timescale 1ns/1ps
module cwp_debug_route #(
  parameter bit PAIR4_PRESENT = 1'b1
) (
  input  wire logic [1:0] sel,
  input  wire logic [1:0] debug_field,
  input  wire logic       cp_active,
  output logic      [3:0] pair_onehot,
  output logic            debugger_en
);

  logic [1:0] eff_debug;

  always_comb
  begin
    pair_onehot = 4'h0;
    unique case (sel)
      cwp_pkg::DBG_SEL_PAIR_ONE:   pair_onehot = 4'h1;
      cwp_pkg::DBG_SEL_PAIR_TWO:   pair_onehot = 4'h2;
      cwp_pkg::DBG_SEL_PAIR_THREE: pair_onehot = 4'h4;
      cwp_pkg::DBG_SEL_PAIR_FOUR:  pair_onehot = PAIR4_PRESENT ? 4'h8 : 4'h0;
    endcase
    // Code protection overrides the programmed debugger field
    eff_debug = cp_active ? cwp_pkg::DEBUG_FORCED_OFF : debug_field;
    debugger_en = ~eff_debug[1];
  end

endmodule : cwp_debug_route

//--- sim/cwp_tool_model.sv
// Programming tool model that assembles configuration word zero
`timescale 1ns/1ps
module cwp_tool_model (
  input  wire logic [15:0] fields,
  output logic      [31:0] word
);
  // Bit 31 reserved low, every other reserved bit high
  assign word = {1'b0, 2'b11, fields[0], 3'b111, fields[1], 5'h1f,
                 fields[10:2], 5'h1f, fields[12:11], fields[13],
                 fields[15:14]};
endmodule : cwp_tool_model

//--- sim/tb.sv
// Self-checking bench for the configuration word zero decoder
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb;
  localparam logic [3:0]  REV   = 4'h2;          // Arbitrary value
  localparam logic [27:0] CODE  = 28'h1234567;   // Arbitrary value
  localparam logic [8:0]  PWP_C [4] = '{9'h1ff, 9'h1fe, 9'h000, 9'h0ff};
  logic        pclk;
  logic        presetn;
  logic [15:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] word;
  logic [19:0] faddr;
  logic        loaded, xblk, bblk, pall, fblk, dben, scen, tdo;
  logic        plock, mlock;
  logic [19:0] bound;
  logic [3:0]  pair;
  logic [15:0] f;
  logic [15:0] s;
  logic [31:0] rd;
  logic [31:0] r;
  logic        err;
  int          fails;
  int          cmp_count;
  logic [19:0] bound_s;
  logic        pall_s;
  logic [3:0]  pair_s;

  cwp_tool_model tool (.fields(f), .word(word));

  cwp_config_word0 #(.FLASH_KB(256), .FA_W(20), .PAIR4_PRESENT(1'b1),
                     .REVISION(REV), .DEVICE_CODE(CODE)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_config_word_zero(word), .flash_write_addr(faddr),
    .config_loaded(loaded), .ext_programmer_block(xblk),
    .boot_flash_write_block(bblk), .program_flash_protect_bound(bound),
    .program_flash_protect_all(pall), .flash_write_blocked(fblk),
    .debug_pin_pair_select(pair), .debugger_enable(dben),
    .scan_port_enable(scen), .test_data_out_enable(tdo),
    .pin_select_lock(plock), .power_module_lock(mlock));

  // Smaller part: seven field bits, no fourth debug pin pair
  cwp_config_word0 #(.FLASH_KB(128), .FA_W(20), .PAIR4_PRESENT(1'b0),
                     .REVISION(REV), .DEVICE_CODE(CODE)) uut_small (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(), .pready(), .pslverr(),
    .boot_config_word_zero(word), .flash_write_addr(faddr),
    .config_loaded(), .ext_programmer_block(),
    .boot_flash_write_block(), .program_flash_protect_bound(bound_s),
    .program_flash_protect_all(pall_s), .flash_write_blocked(),
    .debug_pin_pair_select(pair_s), .debugger_enable(),
    .scan_port_enable(), .test_data_out_enable(),
    .pin_select_lock(), .power_module_lock());

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [19:0] exp_bound(input logic [8:0] p);
    return {1'b0, ~p, 10'h000};
  endfunction : exp_bound

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d, input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      close_out();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic load(input int n);
    r = $urandom();
    if (n < 4)
      r = {16'h0, n[1:0], n[0] ^ n[1], n[1:0], PWP_C[n], n[1], n[0]};
    @(posedge pclk);
    presetn <= 1'b0;
    f <= r[15:0];
    repeat (2) @(posedge pclk);
    #1;
    `CHK(loaded, 1'b0)
    @(posedge pclk);
    presetn <= 1'b1;
    s = f;
    repeat (2) @(posedge pclk);
    #1;
  endtask : load

  task automatic check_dec();
    logic [19:0] a;
    `CHK(loaded, 1'b1)
    `CHK(xblk, ~s[0])
    `CHK(bblk, ~s[1])
    `CHK(bound, exp_bound(s[10:2]))
    `CHK(pall, s[10:2] == 9'h000)
    `CHK(pall | (bound != 20'h0), s[10:2] != 9'h1ff)
    `CHK(pair, 4'b1000 >> s[12:11])
    `CHK(scen, s[13])
    `CHK(dben, s[0] & ~s[15])
    `CHK(bound_s, {3'b000, ~s[8:2], 10'h000})
    `CHK(pall_s, s[8:2] == 7'h00)
    `CHK(pair_s, (4'b1000 >> s[12:11]) & 4'h7)
    for (int k = 0; k < 3; k++)
    begin
      a = (k == 2) ? 20'($urandom()) : exp_bound(s[10:2]) - 20'(k);
      @(posedge pclk);
      faddr <= a;
      @(posedge pclk);
      #1;
      `CHK(fblk, (s[10:2] == 9'h000) | (a < exp_bound(s[10:2])))
    end
    apb(1'b0, 16'he000, 32'h0, 4'h0);
    `CHK(rd, {28'h0, s[13], 3'b011})
    apb(1'b0, 16'he010, 32'h0, 4'h0);
    `CHK(rd, {1'b0, 2'b11, s[0], 3'h7, s[1], 5'h1f, s[10:2], 5'h1f,
              s[12:11], s[13], s[15:14]})
    apb(1'b0, 16'he020, 32'h0, 4'h0);
    `CHK(rd, {7'h00, ~s[10:2], 7'h00, s[0] & ~s[15], 4'b1000 >> s[12:11],
              s[10:2] == 9'h000, ~s[1], ~s[0], 1'b1})
  endtask : check_dec

  task automatic reg_tests();
    apb(1'b0, 16'hf220, 32'h0, 4'h0);
    `CHK(rd, {REV, CODE})
    apb(1'b1, 16'hf220, ~{REV, CODE}, 4'hf);
    apb(1'b0, 16'hf220, 32'h0, 4'h0);
    `CHK(rd, {REV, CODE})
    apb(1'b0, 16'hf230, 32'h0, 4'h0);
    `CHK(rd, 32'h00000000)
    r = $urandom();
    apb(1'b1, 16'hf230, r, 4'hf);
    apb(1'b1, 16'hf230, ~r, 4'h1);
    apb(1'b0, 16'hf230, 32'h0, 4'h0);
    `CHK(rd, {r[31:8], ~r[7:0]})
    apb(1'b1, 16'he000, 32'hffffffff, 4'hf);
    apb(1'b0, 16'he000, 32'h0, 4'h0);
    `CHK(rd, 32'h0000300b)
    `CHK({plock, mlock, scen, tdo}, 4'hf)
    apb(1'b1, 16'he000, 32'h00000000, 4'hf);
    apb(1'b0, 16'he000, 32'h0, 4'h0);
    `CHK(rd, 32'h00000002)
    `CHK({plock, mlock, scen, tdo, err}, 5'h00)
    apb(1'b0, 16'he004, 32'h0, 4'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask : reg_tests

  initial
  begin
    fails = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    faddr = 20'h0;
    f = 16'hffff;
    r = $urandom(33);
    for (int n = 0; n < 12; n++)
    begin
      load(n);
      `CHK({scen, tdo, plock, mlock}, {s[13], 3'b100})
      check_dec();
      @(posedge pclk);
      f <= ~f;
      repeat (3) @(posedge pclk);
      #1;
      check_dec();
      if (n == 0)
        reg_tests();
    end
    close_out();
  end

  initial
  begin
    #500000;
    fails++;
    close_out();
  end
endmodule : tb
